// [design/ssr_top.sv]
// Overview of operation
// - manual reset low forces system reset low regardless of voltages
// - after manual reset rises, reset stays low for one full timeout
// - timeout select low gives 15 ms, high gives 200 ms
// - power-fail warning goes low when power-fail sense falls below threshold
// - power-fail warning releases above threshold plus hysteresis, no timeout
// - system reset goes low when reset sense falls below threshold
// - reset timer starts above threshold plus hysteresis; release after expiry
// - both outputs are low from power-up reset
// - outputs built open-drain or push-pull, chosen by parameter
// - below-threshold results filtered so short dips do not pull outputs low; release is not filtered
// - qualified undervoltage reaches its output within about one millisecond
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.svh"
module ssr_top #(
    parameter bit          OUT_STYLE = `SSR_STYLE_OPEN_DRAIN,
    parameter int          CLK_HZ    = `SSR_CLK_HZ,
    parameter int          SHORT_CYC = CLK_HZ / 1000 * `SSR_TOUT_SHORT_MS,
    parameter int          LONG_CYC  = CLK_HZ / 1000 * `SSR_TOUT_LONG_MS,
    parameter int          FILT_CYC  = CLK_HZ / 1000000 * `SSR_FILT_US
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic manual_reset_in_n,
    input  wire logic timeout_select,
    input  wire logic reset_threshold_below,
    input  wire logic reset_threshold_above_hyst,
    input  wire logic power_fail_below,
    input  wire logic power_fail_above_hyst,
    output logic      sys_reset_n,
    output logic      sys_reset_drv,
    output logic      sys_reset_oe_n,
    output logic      power_fail_warn_n,
    output logic      power_fail_warn_drv,
    output logic      power_fail_warn_oe_n
);
    localparam int CW = `SSR_CNT_W;

    ssr_pkg::ssr_in_t    in_s;
    logic [5:0]          raw;
    logic [5:0]          synced;
    logic                pf_low;
    logic                rst_low;
    ssr_pkg::ssr_state_t st_ff;
    ssr_pkg::ssr_state_t nxt_st;
    logic [CW-1:0]       cnt_ff;
    logic [CW-1:0]       nxt_cnt;
    logic [CW-1:0]       term_ff;
    logic [CW-1:0]       nxt_term;
    ssr_pkg::ssr_pin_t   rst_pin_ff;
    ssr_pkg::ssr_pin_t   pf_pin_ff;
    ssr_pkg::ssr_pin_t   nxt_rst_pin;
    ssr_pkg::ssr_pin_t   nxt_pf_pin;
    logic                abort;

    assign raw = {reset_threshold_above_hyst, reset_threshold_below,
                  power_fail_above_hyst, power_fail_below,
                  manual_reset_in_n, timeout_select};

    // below flags reset high so a reset start looks like undervoltage
    ssr_sync #(
        .W (6)
    ) u_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .d       (raw),
        .rst_val (`SSR_SYNC_RST),
        .q       (synced)
    );
    assign in_s = synced;

    ssr_filter #(
        .FILT_CYC (FILT_CYC),
        .W        (`SSR_FILT_W)
    ) u_pf_filt (
        .clk        (clk),
        .arst_n     (arst_n),
        .below      (in_s.pf_below),
        .above_hyst (in_s.pf_above_hyst),
        .low_ff     (pf_low)
    );

    ssr_filter #(
        .FILT_CYC (FILT_CYC),
        .W        (`SSR_FILT_W)
    ) u_rst_filt (
        .clk        (clk),
        .arst_n     (arst_n),
        .below      (in_s.rst_below),
        .above_hyst (in_s.rst_above_hyst),
        .low_ff     (rst_low)
    );

    assign abort = rst_low || !in_s.man_rst_n;

    // timeout length latched when the timer starts, so a moving strap is harmless
    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_term = term_ff;
        case (st_ff)
            ssr_pkg::SSR_ST_HOLD: begin
                nxt_cnt = '0;
                if (!abort) begin
                    nxt_st   = ssr_pkg::SSR_ST_TIME;
                    nxt_term = in_s.tsel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
                end
            end
            ssr_pkg::SSR_ST_TIME: begin
                if (abort) begin
                    nxt_st  = ssr_pkg::SSR_ST_HOLD;
                    nxt_cnt = '0;
                end else if (cnt_ff >= term_ff) begin
                    nxt_st  = ssr_pkg::SSR_ST_RUN;
                    nxt_cnt = '0;
                end else begin
                    nxt_cnt = cnt_ff + CW'(1);
                end
            end
            ssr_pkg::SSR_ST_RUN: begin
                nxt_cnt = '0;
                if (abort) begin
                    nxt_st = ssr_pkg::SSR_ST_HOLD;
                end
            end
            default: begin
                nxt_st  = ssr_pkg::SSR_ST_HOLD;
                nxt_cnt = '0;
            end
        endcase
    end

    always_comb begin
        nxt_rst_pin.lvl  = (nxt_st == ssr_pkg::SSR_ST_RUN);
        nxt_pf_pin.lvl   = !pf_low;
        // open-drain releases the pin when high; push-pull always drives
        nxt_rst_pin.drv  = nxt_rst_pin.lvl;
        nxt_pf_pin.drv   = nxt_pf_pin.lvl;
        nxt_rst_pin.oe_n = (OUT_STYLE == `SSR_STYLE_OPEN_DRAIN) && nxt_rst_pin.lvl;
        nxt_pf_pin.oe_n  = (OUT_STYLE == `SSR_STYLE_OPEN_DRAIN) && nxt_pf_pin.lvl;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff   <= ssr_pkg::SSR_ST_HOLD;
            cnt_ff  <= '0;
            term_ff <= '0;
        end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            term_ff <= nxt_term;
        end
    end

    // pins come up driven low before any supply check has run
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pin_ff <= `SSR_PIN_RST;
            pf_pin_ff  <= `SSR_PIN_RST;
        end else begin
            rst_pin_ff <= nxt_rst_pin;
            pf_pin_ff  <= nxt_pf_pin;
        end
    end

    assign sys_reset_n          = rst_pin_ff.lvl;
    assign sys_reset_drv        = rst_pin_ff.drv;
    assign sys_reset_oe_n       = rst_pin_ff.oe_n;
    assign power_fail_warn_n    = pf_pin_ff.lvl;
    assign power_fail_warn_drv  = pf_pin_ff.drv;
    assign power_fail_warn_oe_n = pf_pin_ff.oe_n;
endmodule
`default_nettype wire

// [design/ssr_consts.svh]
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// internal time base and timeouts
`define SSR_CLK_HZ          250000000
`define SSR_TOUT_SHORT_MS   15
`define SSR_TOUT_LONG_MS    200
`define SSR_TOUT_SHORT_CYC  (`SSR_CLK_HZ / 1000 * `SSR_TOUT_SHORT_MS)
`define SSR_TOUT_LONG_CYC   (`SSR_CLK_HZ / 1000 * `SSR_TOUT_LONG_MS)
// glitch filter: undervoltage must persist this long, stays under 1 ms
`define SSR_FILT_US         500
`define SSR_FILT_CYC        (`SSR_CLK_HZ / 1000000 * `SSR_FILT_US)
`define SSR_CNT_W           26
`define SSR_FILT_W          18
// output style codes
`define SSR_STYLE_OPEN_DRAIN 1'b0
`define SSR_STYLE_PUSH_PULL  1'b1
// synchroniser reset image: both below flags high, all else low
`define SSR_SYNC_RST         6'h14
// status pins reset driven low
`define SSR_PIN_RST          3'h0

`endif

// [design/ssr_pkg.sv]
`default_nettype none
package ssr_pkg;
    typedef enum logic [1:0] {
        SSR_ST_HOLD = 2'b00,
        SSR_ST_TIME = 2'b01,
        SSR_ST_RUN  = 2'b10
    } ssr_state_t;

    // one status output pin: level, drive and enable (enable low drives)
    typedef struct packed {
        logic lvl;
        logic drv;
        logic oe_n;
    } ssr_pin_t;

    // synchronised comparator and control levels
    typedef struct packed {
        logic rst_above_hyst;
        logic rst_below;
        logic pf_above_hyst;
        logic pf_below;
        logic man_rst_n;
        logic tsel;
    } ssr_in_t;
endpackage
`default_nettype wire

// [design/ssr_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    // flops hold the input flipped by rst_val, so a zero reset reads back as rst_val
    always_comb begin
        nxt_meta = d ^ rst_val;
        nxt_q    = meta_ff;
    end

    // reset value is a constant: rst_val is tied to literals at the instance
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= nxt_meta;
            q_ff    <= nxt_q;
        end
    end

    assign q = q_ff ^ rst_val;
endmodule
`default_nettype wire

// [design/ssr_filter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.svh"
// qualifies an undervoltage only after it persists; clears on rising hysteresis
module ssr_filter #(
    parameter int FILT_CYC = `SSR_FILT_CYC,
    parameter int W        = `SSR_FILT_W
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic below,
    input  wire logic above_hyst,
    output logic      low_ff
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         nxt_low;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_low = low_ff;
        if (low_ff) begin
            nxt_cnt = '0;
            if (above_hyst && !below) begin
                nxt_low = 1'b0;
            end
        end else if (below) begin
            if (cnt_ff >= W'(FILT_CYC - 1)) begin
                nxt_low = 1'b1;
                nxt_cnt = '0;
            end else begin
                nxt_cnt = cnt_ff + W'(1);
            end
        end else begin
            // any recovery restarts the qualification, rejecting short dips
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            low_ff <= 1'b1;
        end else begin
            cnt_ff <= nxt_cnt;
            low_ff <= nxt_low;
        end
    end
endmodule
`default_nettype wire

// [tb/ssr_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// board pull-ups hold a released status pin high
module ssr_cpu_model (
    input  wire logic [3:0] pins,
    output logic            rst_pin,
    output logic            nmi_pin
);
    assign rst_pin = pins[1] ? 1'b1 : pins[0];
    assign nmi_pin = pins[3] ? 1'b1 : pins[2];
endmodule
`default_nettype wire

// [tb/ssr_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_properties #(
    parameter bit OUT_STYLE = 1'b0,
    parameter int SHORT_CYC = 20,
    parameter int LONG_CYC  = 50
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic manual_reset_in_n,
    input wire logic timeout_select,
    input wire logic reset_threshold_below,
    input wire logic reset_threshold_above_hyst,
    input wire logic power_fail_below,
    input wire logic power_fail_above_hyst,
    input wire logic sys_reset_n,
    input wire logic sys_reset_drv,
    input wire logic sys_reset_oe_n,
    input wire logic power_fail_warn_n,
    input wire logic power_fail_warn_drv,
    input wire logic power_fail_warn_oe_n
);
    // unbroken cycles of the release cause; runs are too short to wrap
    logic [15:0] ok_ff;
    logic [15:0] nxt_ok;
    int          lim;
    assign lim = timeout_select ? LONG_CYC : SHORT_CYC;
    always_comb
        nxt_ok = (manual_reset_in_n && reset_threshold_above_hyst && !reset_threshold_below) ?
            ok_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) ok_ff <= 16'h0000;
        else ok_ff <= nxt_ok;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_manual_low: assert property (!manual_reset_in_n [*6] |-> !sys_reset_n)
        else $error("manual reset ignored");
    // release lags its cause by the two sync stages, the filter and the state register
    chk_rel_early: assert property ($rose(sys_reset_n) |-> ok_ff >= lim + 3)
        else $error("reset released early");
    chk_rel_late: assert property (ok_ff == lim + 4 |-> sys_reset_n)
        else $error("reset released late");
    chk_uv_rst: assert property ($rose(reset_threshold_below) |-> ##[1:12]
        (!sys_reset_n || !reset_threshold_below)) else $error("reset missed");
    chk_uv_pf: assert property ($rose(power_fail_below) |-> ##[1:12]
        (!power_fail_warn_n || !power_fail_below)) else $error("warning missed");
    chk_pf_free: assert property ((power_fail_above_hyst && !power_fail_below) [*8]
        |-> power_fail_warn_n) else $error("warning stuck");
    chk_pin_style: assert property (sys_reset_drv == sys_reset_n &&
        sys_reset_oe_n == (OUT_STYLE ? 1'b0 : sys_reset_n)) else $error("reset pin wrong");
    chk_pf_style: assert property (power_fail_warn_drv == power_fail_warn_n &&
        power_fail_warn_oe_n == (OUT_STYLE ? 1'b0 : power_fail_warn_n))
        else $error("warning pin wrong");
    // flops only take reset at the first edge, so look from the second one on
    chk_reset_low: assert property (disable iff (1'b0) (!arst_n) [*2] |->
        !sys_reset_n && !power_fail_warn_n) else $error("output high in reset");
    cover property ($rose(sys_reset_n) && timeout_select);
    cover property ($rose(sys_reset_n) && !timeout_select);
    cover property ($fell(power_fail_warn_n));
endmodule
bind ssr_top ssr_properties #(
    .OUT_STYLE (OUT_STYLE),
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
) u_chk (
    .clk                        (clk),
    .arst_n                     (arst_n),
    .manual_reset_in_n          (manual_reset_in_n),
    .timeout_select             (timeout_select),
    .reset_threshold_below      (reset_threshold_below),
    .reset_threshold_above_hyst (reset_threshold_above_hyst),
    .power_fail_below           (power_fail_below),
    .power_fail_above_hyst      (power_fail_above_hyst),
    .sys_reset_n                (sys_reset_n),
    .sys_reset_drv              (sys_reset_drv),
    .sys_reset_oe_n             (sys_reset_oe_n),
    .power_fail_warn_n          (power_fail_warn_n),
    .power_fail_warn_drv        (power_fail_warn_drv),
    .power_fail_warn_oe_n       (power_fail_warn_oe_n)
);
`default_nettype wire

// [tb/test_supply_supervisor_reset_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module test_supply_supervisor_reset_logic;
    logic       clk = 1'b0, arst_n = 1'b0, req = 1'b0, man_n = 1'b1, tsel = 1'b0;
    logic       r_lo = 1'b0, r_hi = 1'b1, p_lo = 1'b0, p_hi = 1'b1;
    wire        rst_pin, pf_pin;
    wire  [3:0] pins;
    wire  [3:0] pp;
    logic [1:0] exp_q[$];
    logic [1:0] exp_now;
    int         mismatches = 0, cmp_count = 0;
    always #2 clk = ~clk;
    ssr_top #(.SHORT_CYC(20), .LONG_CYC(50), .FILT_CYC(5)) dut (.clk(clk), .arst_n(arst_n),
        .manual_reset_in_n(man_n), .timeout_select(tsel), .reset_threshold_below(r_lo),
        .reset_threshold_above_hyst(r_hi), .power_fail_below(p_lo),
        .power_fail_above_hyst(p_hi), .sys_reset_n(), .sys_reset_drv(pins[0]),
        .sys_reset_oe_n(pins[1]), .power_fail_warn_n(), .power_fail_warn_drv(pins[2]),
        .power_fail_warn_oe_n(pins[3]));
    // push-pull twin on the same stimulus: pins always driven, level as the open-drain one
    ssr_top #(.OUT_STYLE(1'b1), .SHORT_CYC(20), .LONG_CYC(50), .FILT_CYC(5)) dut_pp (.clk(clk),
        .arst_n(arst_n), .manual_reset_in_n(man_n), .timeout_select(tsel),
        .reset_threshold_below(r_lo), .reset_threshold_above_hyst(r_hi),
        .power_fail_below(p_lo), .power_fail_above_hyst(p_hi), .sys_reset_n(),
        .sys_reset_drv(pp[0]), .sys_reset_oe_n(pp[1]), .power_fail_warn_n(),
        .power_fail_warn_drv(pp[2]), .power_fail_warn_oe_n(pp[3]));
    ssr_cpu_model model (.pins(pins), .rst_pin(rst_pin), .nmi_pin(pf_pin));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic note(input logic [1:0] e);
        exp_q.push_back(e);
        req <= 1'b1;
        cyc(1);
        req <= 1'b0;
        cyc(1);
    endtask
    // cycles from the call until the reset pin rises
    task automatic wait_rel(input int lim);
        int n;
        for (n = 0; rst_pin !== 1'b1; n++) begin
            if (n > 400) begin
                mismatches++;
                end_sim();
            end
            cyc(1);
        end
        check({7'h00, n >= lim && n <= lim + 12}, 8'h01);
    endtask
    always @(posedge clk) begin
        if (req) begin
            exp_now = exp_q.pop_front();
            check({6'h00, rst_pin, pf_pin}, {6'h00, exp_now});
            check({4'h0, pp}, {4'h0, 1'b0, exp_now[0], 1'b0, exp_now[1]});
        end
    end
    initial begin
        void'($urandom(32'h37d0_742b));
        cyc(4);
        note(2'b00);
        cyc(6);
        arst_n <= 1'b1;
        cyc(10);
        note(2'b01);
        wait_rel(8);
        // pass 0 long manual, pass 1 short manual re-pressed, pass 2 undervoltage
        for (int i = 0; i < 3; i++) begin
            tsel <= (i == 0);
            man_n <= (i == 2);
            r_lo <= (i == 2);
            r_hi <= (i != 2);
            cyc(12);
            note(2'b01);
            man_n <= 1'b1;
            r_lo <= 1'b0;
            cyc(i * 9);
            note(2'b01);
            man_n <= (i != 1);
            cyc(3);
            man_n <= 1'b1;
            r_hi <= 1'b1;
            wait_rel(i == 0 ? 45 : 20);
        end
        repeat (6) begin
            p_lo <= 1'b1;
            cyc($urandom_range(3, 1));
            p_lo <= 1'b0;
            cyc($urandom_range(9, 4));
        end
        note(2'b11);
        p_lo <= 1'b1;
        p_hi <= 1'b0;
        cyc(12);
        note(2'b10);
        p_lo <= 1'b0;
        cyc(20);
        note(2'b10);
        p_hi <= 1'b1;
        cyc(6);
        note(2'b11);
        end_sim();
    end
endmodule
`default_nettype wire
